// ### pkg/bsp_pkg.sv
// package: register map, strap field layout, pin mux constants for the strap status block
package bsp_pkg;
  // =====================================================================
  // register map
  localparam logic [31:0] STATUS_ADDR = 32'h01b3f004; // device_strap_status, read only
  localparam logic [31:0] PINCFG_ADDR = 32'h01b3f040; // pin config: gpio enable/dir, video/audio selects
  localparam logic [31:0] STATUS_MASK = 32'h00000c7f; // implemented status bits
  localparam logic [31:0] PINCFG_MASK = 32'h000003f3; // implemented pin config bits, 11:10 and 3:2 unused
  localparam logic [31:0] PINCFG_RST = 32'h00000000; // everything off after reset
  // =====================================================================
  // status field positions
  localparam int ETH_EN_BIT = 11;
  localparam int HPW_BIT = 10;
  localparam int PLL_HI = 6;
  localparam int PLL_LO = 5;
  localparam int BYTE_ORDER_BIT = 4;
  localparam int BOOT_HI = 3;
  localparam int BOOT_LO = 2;
  localparam int EXTCLK_HI = 1;
  localparam int EXTCLK_LO = 0;
  // =====================================================================
  // pin config field positions
  localparam int GP1_EN_BIT = 0;
  localparam int GP2_EN_BIT = 1;
  localparam int GP8_EN_BIT = 4;
  localparam int GP1_DIR_BIT = 5;
  localparam int GP2_DIR_BIT = 6;
  localparam int GP8_DIR_BIT = 7;
  localparam int VP1_EN_BIT = 8;
  localparam int AUD_SEL_BIT = 9;
  // =====================================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // upper data pin group owner
  typedef enum logic [2:0] {
    BSP_UPPER_NONE = 3'h1,
    BSP_UPPER_VIDEO = 3'h2,
    BSP_UPPER_AUDIO = 3'h4
  } bsp_upper_type;
endpackage

// ### core/bsp_capture.sv
// strap capture register: loads once in the cycle after reset release, then holds
`timescale 1ns/1ns
`default_nettype none
module bsp_capture #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic done
);
  // =====================================================================
  // capture: first clock with reset released takes the pins, later pin activity is ignored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
      done <= 1'b0;
    end else if (!done) begin
      q <= d;
      done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### core/bsp_top.sv
// strap status register and shared pin multiplexer behind an axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - reserved status bits read zero, writes ignored
// - bit 11 shows ethernet enable strap
// - bit 10 shows host port width
// - bits 6:5 show cpu pll multiplier
// - bit 4 shows byte order strap
// - bits 3:2 show boot source
// - bits 1:0 show extmem clock source
// - shared pins muxed by software through the pin config register
// - strap pin groups owned by one peripheral
// - clock out pins default, gpio when enabled
// - dac pin default, gpio when enabled
// - video upper pins only when enabled, audio off
// - audio select routes upper pins to audio
module bsp_top (
  input wire logic CLK,
  input wire logic NRST,
  // strap pin levels
  input wire logic ETHERNET_ENABLE_STRAP,
  input wire logic HOST_PORT_WIDTH_SEL,
  input wire logic [1:0] CPU_PLL_MULTIPLIER_SEL,
  input wire logic BYTE_ORDER_STRAP,
  input wire logic [1:0] BOOT_MODE_SEL,
  input wire logic [1:0] EXTMEM_CLOCK_SOURCE_SEL,
  // axi4-lite slave
  input wire logic [31:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [31:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // peripheral sources for the shared pins
  input wire logic CPU_DIV4_CLOCK_OUT,
  input wire logic CPU_DIV6_CLOCK_OUT,
  input wire logic OSCILLATOR_DAC_OUTPUT,
  input wire logic [2:0] GPIO_OUT,
  input wire logic [7:0] VIDEO_UPPER_OUT,
  input wire logic [7:0] AUDIO_DATA_OUT,
  input wire logic [7:0] AUDIO_DATA_DIR,
  // shared pins: 0 cpu_div4_clock_out/gp1, 1 cpu_div6_clock_out/gp2, 2 dac/gp8
  input wire logic [2:0] MISC_PIN_IN,
  output logic [2:0] MISC_PIN_OUT,
  output logic [2:0] MISC_PIN_OE_N,
  input wire logic [7:0] UPPER_PIN_IN,
  output logic [7:0] UPPER_PIN_OUT,
  output logic [7:0] UPPER_PIN_OE_N,
  // pin input returns and owner flags
  output logic [2:0] GPIO_IN,
  output logic [7:0] VIDEO_UPPER_IN,
  output logic [7:0] AUDIO_DATA_IN,
  output logic ETHERNET_CONTROLLER_EN,
  output logic VIDEO_UPPER_ACTIVE,
  output logic AUDIO_PORT_ACTIVE
);
  // =====================================================================
  // strap capture
  logic [11:0] strap_bus; // raw pin levels packed in status order
  logic [11:0] strap_q; // captured copy
  logic strap_done; // capture has happened
  logic [31:0] status_word; // read value of device_strap_status
  logic [31:0] pincfg_r; // software pin configuration

  always_comb begin
    strap_bus = '0;
    strap_bus[bsp_pkg::ETH_EN_BIT] = ETHERNET_ENABLE_STRAP;
    strap_bus[bsp_pkg::HPW_BIT] = HOST_PORT_WIDTH_SEL;
    strap_bus[bsp_pkg::PLL_HI:bsp_pkg::PLL_LO] = CPU_PLL_MULTIPLIER_SEL;
    strap_bus[bsp_pkg::BYTE_ORDER_BIT] = BYTE_ORDER_STRAP;
    strap_bus[bsp_pkg::BOOT_HI:bsp_pkg::BOOT_LO] = BOOT_MODE_SEL;
    strap_bus[bsp_pkg::EXTCLK_HI:bsp_pkg::EXTCLK_LO] = EXTMEM_CLOCK_SOURCE_SEL;
  end

  // one capture register keeps every strap field in step
  bsp_capture #(.W(12)) u_capture (
    .clk(CLK),
    .nrst(NRST),
    .d(strap_bus),
    .q(strap_q),
    .done(strap_done)
  );

  // =====================================================================
  // status word: fields placed at their bit positions, reserved bits forced low
  always_comb begin
    status_word = '0;
    status_word[bsp_pkg::ETH_EN_BIT] = strap_q[bsp_pkg::ETH_EN_BIT];
    status_word[bsp_pkg::HPW_BIT] = strap_q[bsp_pkg::HPW_BIT];
    status_word[bsp_pkg::PLL_HI:bsp_pkg::PLL_LO] = strap_q[bsp_pkg::PLL_HI:bsp_pkg::PLL_LO];
    status_word[bsp_pkg::BYTE_ORDER_BIT] = strap_q[bsp_pkg::BYTE_ORDER_BIT];
    status_word[bsp_pkg::BOOT_HI:bsp_pkg::BOOT_LO] = strap_q[bsp_pkg::BOOT_HI:bsp_pkg::BOOT_LO];
    status_word[bsp_pkg::EXTCLK_HI:bsp_pkg::EXTCLK_LO] = strap_q[bsp_pkg::EXTCLK_HI:bsp_pkg::EXTCLK_LO];
    status_word = status_word & bsp_pkg::STATUS_MASK;
  end

  // =====================================================================
  // axi4-lite write channel: takes address and data in either order
  logic aw_held_r; // address taken, waiting for data
  logic w_held_r; // data taken, waiting for address
  logic [31:0] awaddr_r; // latched write address
  logic [31:0] wdata_r; // latched write data
  logic [3:0] wstrb_r; // latched strobes
  logic aw_take; // address handshake this cycle
  logic w_take; // data handshake this cycle
  logic wr_go; // both halves present, commit now

  assign aw_take = AWVALID && AWREADY;
  assign w_take = WVALID && WREADY;
  assign wr_go = (aw_held_r || aw_take) && (w_held_r || w_take) && !BVALID;

  // address half
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      AWREADY <= 1'b0;
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else begin
      if (aw_take) begin
        awaddr_r <= AWADDR;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        AWREADY <= 1'b0; // reopened after the response is taken
      end else if (aw_take) begin
        aw_held_r <= 1'b1;
        AWREADY <= 1'b0;
      end else if (!aw_held_r && !BVALID) begin
        AWREADY <= 1'b1;
      end
    end
  end

  // data half
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      WREADY <= 1'b0;
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (w_take) begin
        wdata_r <= WDATA;
        wstrb_r <= WSTRB;
      end
      if (wr_go) begin
        w_held_r <= 1'b0;
        WREADY <= 1'b0;
      end else if (w_take) begin
        w_held_r <= 1'b1;
        WREADY <= 1'b0;
      end else if (!w_held_r && !BVALID) begin
        WREADY <= 1'b1;
      end
    end
  end

  // commit: pick fresh or held halves
  logic [31:0] wr_addr; // effective write address
  logic [31:0] wr_data; // effective write data
  logic [3:0] wr_strb; // effective strobes
  logic [31:0] wr_bytes; // strobes expanded to a bit mask
  assign wr_addr = aw_take ? AWADDR : awaddr_r;
  assign wr_data = w_take ? WDATA : wdata_r;
  assign wr_strb = w_take ? WSTRB : wstrb_r;
  assign wr_bytes = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // pin configuration register; writing the status register is accepted but changes nothing
  // software is expected to program this once at init; a later change switches pins live
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pincfg_r <= bsp_pkg::PINCFG_RST;
    end else if (wr_go && wr_addr == bsp_pkg::PINCFG_ADDR) begin
      pincfg_r <= ((pincfg_r & ~wr_bytes) | (wr_data & wr_bytes)) & bsp_pkg::PINCFG_MASK;
    end
  end

  // write response: status write is okay but ignored, unmapped gets slverr
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      BVALID <= 1'b0;
      BRESP <= bsp_pkg::RESP_OKAY;
    end else if (wr_go) begin
      BVALID <= 1'b1;
      if (wr_addr == bsp_pkg::STATUS_ADDR) begin
        BRESP <= bsp_pkg::RESP_OKAY;
      end else if (wr_addr == bsp_pkg::PINCFG_ADDR) begin
        BRESP <= bsp_pkg::RESP_OKAY;
      end else begin
        BRESP <= bsp_pkg::RESP_SLVERR;
      end
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // =====================================================================
  // axi4-lite read channel: one read at a time, answer one cycle after the address
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= bsp_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      if (ARADDR == bsp_pkg::STATUS_ADDR) begin
        RDATA <= status_word;
        RRESP <= bsp_pkg::RESP_OKAY;
      end else if (ARADDR == bsp_pkg::PINCFG_ADDR) begin
        RDATA <= pincfg_r;
        RRESP <= bsp_pkg::RESP_OKAY;
      end else begin
        RDATA <= '0;
        RRESP <= bsp_pkg::RESP_SLVERR;
      end
    end else if (RVALID) begin
      if (RREADY) begin
        RVALID <= 1'b0;
      end
    end else begin
      ARREADY <= 1'b1;
    end
  end

  // =====================================================================
  // pin multiplexing
  logic [2:0] gp_en; // gpio enable per shared pin
  logic [2:0] gp_dir; // gpio direction per shared pin, 1 = output
  logic [2:0] dflt_out; // default function per shared pin
  logic [2:0] misc_out_nxt;
  logic [2:0] misc_oe_n_nxt;
  bsp_pkg::bsp_upper_type upper_own; // owner of the upper data pins
  assign gp_en = {pincfg_r[bsp_pkg::GP8_EN_BIT], pincfg_r[bsp_pkg::GP2_EN_BIT], pincfg_r[bsp_pkg::GP1_EN_BIT]};
  assign gp_dir = {pincfg_r[bsp_pkg::GP8_DIR_BIT], pincfg_r[bsp_pkg::GP2_DIR_BIT], pincfg_r[bsp_pkg::GP1_DIR_BIT]};
  assign dflt_out = {OSCILLATOR_DAC_OUTPUT, CPU_DIV6_CLOCK_OUT, CPU_DIV4_CLOCK_OUT};

  // clock and dac pins: default function unless gpio is enabled
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (gp_en[i]) begin
        misc_out_nxt[i] = GPIO_OUT[i];
        misc_oe_n_nxt[i] = !gp_dir[i];
      end else begin
        misc_out_nxt[i] = dflt_out[i];
        misc_oe_n_nxt[i] = 1'b0;
      end
    end
  end

  // upper data pins: audio select wins, video only when enabled, else unowned
  always_comb begin
    if (pincfg_r[bsp_pkg::AUD_SEL_BIT]) begin
      upper_own = bsp_pkg::BSP_UPPER_AUDIO;
    end else if (pincfg_r[bsp_pkg::VP1_EN_BIT]) begin
      upper_own = bsp_pkg::BSP_UPPER_VIDEO;
    end else begin
      upper_own = bsp_pkg::BSP_UPPER_NONE;
    end
  end

  // registered pin drive; pins stay undriven until straps are captured
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      MISC_PIN_OUT <= '0;
      MISC_PIN_OE_N <= '1;
      UPPER_PIN_OUT <= '0;
      UPPER_PIN_OE_N <= '1;
      VIDEO_UPPER_ACTIVE <= 1'b0;
      AUDIO_PORT_ACTIVE <= 1'b0;
    end else begin
      MISC_PIN_OUT <= misc_out_nxt;
      MISC_PIN_OE_N <= strap_done ? misc_oe_n_nxt : '1;
      VIDEO_UPPER_ACTIVE <= (upper_own == bsp_pkg::BSP_UPPER_VIDEO);
      AUDIO_PORT_ACTIVE <= (upper_own == bsp_pkg::BSP_UPPER_AUDIO);
      case (upper_own)
        bsp_pkg::BSP_UPPER_AUDIO: begin
          UPPER_PIN_OUT <= AUDIO_DATA_OUT;
          UPPER_PIN_OE_N <= ~AUDIO_DATA_DIR;
        end
        bsp_pkg::BSP_UPPER_VIDEO: begin
          UPPER_PIN_OUT <= VIDEO_UPPER_OUT;
          UPPER_PIN_OE_N <= '1; // video capture: input only here
        end
        default: begin
          UPPER_PIN_OUT <= '0;
          UPPER_PIN_OE_N <= '1;
        end
      endcase
    end
  end

  // input returns, gated by owner so an idle peripheral sees zeros
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      GPIO_IN <= '0;
      VIDEO_UPPER_IN <= '0;
      AUDIO_DATA_IN <= '0;
      ETHERNET_CONTROLLER_EN <= 1'b0;
    end else begin
      GPIO_IN <= MISC_PIN_IN & gp_en;
      VIDEO_UPPER_IN <= (upper_own == bsp_pkg::BSP_UPPER_VIDEO) ? UPPER_PIN_IN : '0;
      AUDIO_DATA_IN <= (upper_own == bsp_pkg::BSP_UPPER_AUDIO) ? UPPER_PIN_IN : '0;
      ETHERNET_CONTROLLER_EN <= strap_q[bsp_pkg::ETH_EN_BIT];
    end
  end

  // =====================================================================
  // checks
  chk_reserved_zero: assert property (@(posedge CLK) disable iff (!NRST)
    RVALID |-> ((RDATA & ~bsp_pkg::STATUS_MASK & ~bsp_pkg::PINCFG_MASK) == 32'h0))
    else $error("reserved read bits not zero");
  chk_status_eth_bit: assert property (@(posedge CLK) disable iff (!NRST)
    (ARVALID && ARREADY && ARADDR == bsp_pkg::STATUS_ADDR) |=>
    RDATA[bsp_pkg::ETH_EN_BIT] == strap_q[bsp_pkg::ETH_EN_BIT])
    else $error("ethernet status bit wrong");
  chk_status_reserved: assert property (@(posedge CLK) disable iff (!NRST)
    (ARVALID && ARREADY && ARADDR == bsp_pkg::STATUS_ADDR) |=> ((RDATA & ~bsp_pkg::STATUS_MASK) == 32'h0))
    else $error("status reserved bits not zero");
  chk_status_pll_field: assert property (@(posedge CLK) disable iff (!NRST)
    (ARVALID && ARREADY && ARADDR == bsp_pkg::STATUS_ADDR) |=>
    RDATA[bsp_pkg::PLL_HI:bsp_pkg::PLL_LO] == strap_q[bsp_pkg::PLL_HI:bsp_pkg::PLL_LO])
    else $error("pll multiplier field wrong");
  chk_strap_hold: assert property (@(posedge CLK) disable iff (!NRST)
    $past(strap_done) |-> $stable(strap_q))
    else $error("strap capture changed after reset");
  chk_misc_gpio_mode: assert property (@(posedge CLK) disable iff (!NRST)
    (strap_done && gp_en[0] && !gp_dir[0]) |=> MISC_PIN_OE_N[0])
    else $error("gpio input pin driven");
  chk_dac_default_drive: assert property (@(posedge CLK) disable iff (!NRST)
    (strap_done && !gp_en[2]) |=> (!MISC_PIN_OE_N[2] && MISC_PIN_OUT[2] == $past(OSCILLATOR_DAC_OUTPUT)))
    else $error("dac pin not driven by dac");
  chk_upper_exclusive: assert property (@(posedge CLK) disable iff (!NRST)
    !(VIDEO_UPPER_ACTIVE && AUDIO_PORT_ACTIVE))
    else $error("upper pins owned twice");
  chk_audio_select_wins: assert property (@(posedge CLK) disable iff (!NRST)
    pincfg_r[bsp_pkg::AUD_SEL_BIT] |=> (AUDIO_PORT_ACTIVE && !VIDEO_UPPER_ACTIVE))
    else $error("audio select did not take pins");
endmodule
`default_nettype wire

// ### sim/bsp_top_tb_top.sv
// testbench: strap status register and shared pin mux driven over axi4-lite
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module bsp_top_tb_top;
  // =====================================================================
  // signals
  logic CLK, NRST, ETHERNET_ENABLE_STRAP, HOST_PORT_WIDTH_SEL, BYTE_ORDER_STRAP;
  logic [1:0] CPU_PLL_MULTIPLIER_SEL, BOOT_MODE_SEL, EXTMEM_CLOCK_SOURCE_SEL, BRESP, RRESP;
  logic [31:0] AWADDR, WDATA, ARADDR, RDATA;
  logic [3:0] WSTRB;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic CPU_DIV4_CLOCK_OUT, CPU_DIV6_CLOCK_OUT, OSCILLATOR_DAC_OUTPUT;
  logic [2:0] GPIO_OUT, MISC_PIN_IN, MISC_PIN_OUT, MISC_PIN_OE_N, GPIO_IN;
  logic [7:0] VIDEO_UPPER_OUT, AUDIO_DATA_OUT, AUDIO_DATA_DIR, UPPER_PIN_IN, UPPER_PIN_OUT, UPPER_PIN_OE_N;
  logic [7:0] VIDEO_UPPER_IN, AUDIO_DATA_IN;
  logic ETHERNET_CONTROLLER_EN, VIDEO_UPPER_ACTIVE, AUDIO_PORT_ACTIVE;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] d;
  logic [1:0] r;
  // design under test
  bsp_top bsp_top_i (.CLK(CLK), .NRST(NRST), .ETHERNET_ENABLE_STRAP(ETHERNET_ENABLE_STRAP),
    .HOST_PORT_WIDTH_SEL(HOST_PORT_WIDTH_SEL), .CPU_PLL_MULTIPLIER_SEL(CPU_PLL_MULTIPLIER_SEL),
    .BYTE_ORDER_STRAP(BYTE_ORDER_STRAP), .BOOT_MODE_SEL(BOOT_MODE_SEL), .EXTMEM_CLOCK_SOURCE_SEL(EXTMEM_CLOCK_SOURCE_SEL),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CPU_DIV4_CLOCK_OUT(CPU_DIV4_CLOCK_OUT), .CPU_DIV6_CLOCK_OUT(CPU_DIV6_CLOCK_OUT),
    .OSCILLATOR_DAC_OUTPUT(OSCILLATOR_DAC_OUTPUT), .GPIO_OUT(GPIO_OUT), .VIDEO_UPPER_OUT(VIDEO_UPPER_OUT),
    .AUDIO_DATA_OUT(AUDIO_DATA_OUT), .AUDIO_DATA_DIR(AUDIO_DATA_DIR), .MISC_PIN_IN(MISC_PIN_IN),
    .MISC_PIN_OUT(MISC_PIN_OUT), .MISC_PIN_OE_N(MISC_PIN_OE_N), .UPPER_PIN_IN(UPPER_PIN_IN),
    .UPPER_PIN_OUT(UPPER_PIN_OUT), .UPPER_PIN_OE_N(UPPER_PIN_OE_N), .GPIO_IN(GPIO_IN),
    .VIDEO_UPPER_IN(VIDEO_UPPER_IN), .AUDIO_DATA_IN(AUDIO_DATA_IN), .ETHERNET_CONTROLLER_EN(ETHERNET_CONTROLLER_EN),
    .VIDEO_UPPER_ACTIVE(VIDEO_UPPER_ACTIVE), .AUDIO_PORT_ACTIVE(AUDIO_PORT_ACTIVE));
  // =====================================================================
  // clock, 8 ns period
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // =====================================================================
  // helpers
  // expected status word for strap case i, positions written out independently of the package
  function automatic logic [31:0] stat(input logic [1:0] i);
    logic [31:0] v;
    v = 32'h00000000;
    v[11] = i[0];
    v[10] = i[1];
    v[6:5] = i;
    v[4] = ~i[0];
    v[3:2] = i ^ 2'h1;
    v[1:0] = i;
    return v;
  endfunction
  // straps settle while reset is low so they are stable at the capture edge
  task automatic do_reset(input logic [1:0] i);
    @(posedge CLK);
    NRST <= 1'b0;
    ETHERNET_ENABLE_STRAP <= i[0];
    HOST_PORT_WIDTH_SEL <= i[1];
    CPU_PLL_MULTIPLIER_SEL <= i;
    BYTE_ORDER_STRAP <= ~i[0];
    BOOT_MODE_SEL <= i ^ 2'h1;
    EXTMEM_CLOCK_SOURCE_SEL <= i;
    repeat (10) @(posedge CLK);
    #1;
    `CHK("misc oe_n in reset", 3'h7, MISC_PIN_OE_N)
    @(posedge CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK);
  endtask
  // one axi4-lite write, address and data offered together, each released when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw, w, b;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    @(posedge CLK);
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= v;
    WSTRB <= 4'hf;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    // no cycle count assumed: only the watchdog ends a wait that never answers
    while (!b) begin
      @(posedge CLK);
      if (aw && w && BVALID === 1'b1) begin
        b = 1'b1;
        resp = BRESP;
        BREADY <= 1'b0;
      end
      if (!aw && AWREADY === 1'b1) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end
  endtask
  // one axi4-lite read
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar, rr;
    ar = 1'b0;
    rr = 1'b0;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!rr) begin
      @(posedge CLK);
      if (ar && RVALID === 1'b1) begin
        rr = 1'b1;
        v = RDATA;
        resp = RRESP;
        RREADY <= 1'b0;
      end
      if (!ar && ARREADY === 1'b1) begin
        ar = 1'b1;
        ARVALID <= 1'b0;
      end
    end
  endtask
  // pin selects are set once after a fresh reset, never switched while running
  task automatic pin_cfg(input logic [31:0] v);
    do_reset(2'h3);
    axi_wr(bsp_pkg::PINCFG_ADDR, v, r);
    `CHK("pincfg bresp", bsp_pkg::RESP_OKAY, r)
    repeat (3) @(posedge CLK);
    #1;
  endtask
  // verdict, reached from the main sequence or the watchdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: whole sequence needs well under a thousand cycles
  initial begin
    #40000;
    bad_count++;
    wrap_up();
  end
  // =====================================================================
  // tests
  initial begin
    NRST = 1'b0;
    {ETHERNET_ENABLE_STRAP, HOST_PORT_WIDTH_SEL, BYTE_ORDER_STRAP} = 3'h0;
    {CPU_PLL_MULTIPLIER_SEL, BOOT_MODE_SEL, EXTMEM_CLOCK_SOURCE_SEL} = 6'h00;
    {AWADDR, WDATA, ARADDR, WSTRB} = 100'h0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {CPU_DIV4_CLOCK_OUT, CPU_DIV6_CLOCK_OUT, OSCILLATOR_DAC_OUTPUT} = 3'h5;
    GPIO_OUT = 3'h6;
    MISC_PIN_IN = 3'h5;
    VIDEO_UPPER_OUT = 8'h5a;
    AUDIO_DATA_OUT = 8'ha5;
    AUDIO_DATA_DIR = 8'h0f;
    UPPER_PIN_IN = 8'h3c;
    // every code of each strap field, then strap pins toggled after capture
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0]);
      axi_rd(bsp_pkg::STATUS_ADDR, d, r);
      `CHK("status", stat(i[1:0]), d)
      `CHK("status rresp", bsp_pkg::RESP_OKAY, r)
      `CHK("eth enable", i[0], ETHERNET_CONTROLLER_EN)
      @(posedge CLK);
      {ETHERNET_ENABLE_STRAP, HOST_PORT_WIDTH_SEL, BYTE_ORDER_STRAP} <= ~{i[0], i[1], ~i[0]};
      {CPU_PLL_MULTIPLIER_SEL, BOOT_MODE_SEL, EXTMEM_CLOCK_SOURCE_SEL} <= ~{i[1:0], i[1:0] ^ 2'h1, i[1:0]};
      axi_rd(bsp_pkg::STATUS_ADDR, d, r);
      `CHK("status held", stat(i[1:0]), d)
    end
    $display("test strap capture done");
    // defaults after reset: clock outs and dac drive, upper pins unowned
    #1;
    `CHK("misc out default", {OSCILLATOR_DAC_OUTPUT, CPU_DIV6_CLOCK_OUT, CPU_DIV4_CLOCK_OUT}, MISC_PIN_OUT)
    `CHK("misc oe_n default", 3'h0, MISC_PIN_OE_N)
    `CHK("upper oe_n default", 8'hff, UPPER_PIN_OE_N)
    `CHK("owners default", 2'h0, {VIDEO_UPPER_ACTIVE, AUDIO_PORT_ACTIVE})
    // status is read only, unmapped place answers with an error
    axi_wr(bsp_pkg::STATUS_ADDR, 32'hffffffff, r);
    `CHK("status wr bresp", bsp_pkg::RESP_OKAY, r)
    axi_rd(bsp_pkg::STATUS_ADDR, d, r);
    `CHK("status after wr", stat(2'h3), d)
    axi_wr(32'h01b3f100, 32'hffffffff, r);
    `CHK("unmapped bresp", bsp_pkg::RESP_SLVERR, r)
    axi_rd(32'h01b3f100, d, r);
    `CHK("unmapped rresp", bsp_pkg::RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h00000000, d)
    $display("test access kinds done");
    // all gpio outputs, video enable and audio select together: audio wins
    pin_cfg(32'hffffffff);
    `CHK("misc out gpio", GPIO_OUT, MISC_PIN_OUT)
    `CHK("misc oe_n gpio out", 3'h0, MISC_PIN_OE_N)
    `CHK("upper out audio", AUDIO_DATA_OUT, UPPER_PIN_OUT)
    `CHK("upper oe_n audio", ~AUDIO_DATA_DIR, UPPER_PIN_OE_N)
    `CHK("audio in", UPPER_PIN_IN, AUDIO_DATA_IN)
    `CHK("video in off", 8'h00, VIDEO_UPPER_IN)
    `CHK("owners audio", 2'h1, {VIDEO_UPPER_ACTIVE, AUDIO_PORT_ACTIVE})
    axi_rd(bsp_pkg::PINCFG_ADDR, d, r);
    `CHK("pincfg readback", bsp_pkg::PINCFG_MASK, d)
    // gpio inputs and video port owning the upper pins
    MISC_PIN_IN <= 3'h2;
    pin_cfg(32'h00000113);
    `CHK("misc oe_n gpio in", 3'h7, MISC_PIN_OE_N)
    `CHK("gpio in", 3'h2, GPIO_IN)
    `CHK("video in", UPPER_PIN_IN, VIDEO_UPPER_IN)
    `CHK("audio in off", 8'h00, AUDIO_DATA_IN)
    `CHK("upper oe_n video", 8'hff, UPPER_PIN_OE_N)
    `CHK("upper out video", VIDEO_UPPER_OUT, UPPER_PIN_OUT)
    `CHK("owners video", 2'h2, {VIDEO_UPPER_ACTIVE, AUDIO_PORT_ACTIVE})
    // back to defaults
    pin_cfg(32'h00000000);
    `CHK("misc out back", {OSCILLATOR_DAC_OUTPUT, CPU_DIV6_CLOCK_OUT, CPU_DIV4_CLOCK_OUT}, MISC_PIN_OUT)
    `CHK("gpio in off", 3'h0, GPIO_IN)
    `CHK("owners none", 2'h0, {VIDEO_UPPER_ACTIVE, AUDIO_PORT_ACTIVE})
    `CHK("upper out none", 8'h00, UPPER_PIN_OUT)
    `CHK("upper oe_n none", 8'hff, UPPER_PIN_OE_N)
    $display("test pin mux done");
    wrap_up();
  end
endmodule
`default_nettype wire
